// ===== rtl/cfa_map.svh
// constants of the converter fault aggregator: register indices, byte
// addresses, field positions, reset values
// assumes an APB slave whose byte address is four times a register index
//
// Function
// - The summary bit is one while any flag is set with its mask bit clear.
// - When selected, the summary bit drives the status output pin.
// - Bit 4 of the fault flags is set whenever the PLL is out of lock.
// - Bit 3 is set while the link is enabled but not in data encoding.
// - Bit 2 is set whenever a SYSREF event realigns the internal clocks.
// - Bit 1 is set on link disable, oscillator resync or A/B phase skew.
// - Bit 0 is set whenever the A and B clock dividers disagree.
// - A flag stays set until a one is written to it; a zero leaves it.
// - After reset the fault flags read 0x1F with the upper three bits clear.
// - A set mask bit keeps its flag out of the summary, flag untouched.
// - After reset the mask reads 0x1F so no fault reaches the summary bit.
// - Summary bits 7:1 read zero; flag and mask bits 7:5 are writable.
`ifndef CFA_MAP_SVH
`define CFA_MAP_SVH

`define CFA_NFLAG        5
`define CFA_IDX_SUMMARY  10'h2C0
`define CFA_IDX_FLAGS    10'h2C1
`define CFA_IDX_MASK     10'h2C2
`define CFA_IDX_CTRL     10'h2C3
`define CFA_IDX_LIVE     10'h2C4
`define CFA_ADDR_SUMMARY {`CFA_IDX_SUMMARY, 2'b00}
`define CFA_ADDR_FLAGS   {`CFA_IDX_FLAGS, 2'b00}
`define CFA_ADDR_MASK    {`CFA_IDX_MASK, 2'b00}
`define CFA_ADDR_CTRL    {`CFA_IDX_CTRL, 2'b00}
`define CFA_ADDR_LIVE    {`CFA_IDX_LIVE, 2'b00}
`define CFA_BIT_LOCK     4
`define CFA_BIT_LINK     3
`define CFA_BIT_REALIGN  2
`define CFA_BIT_OSC      1
`define CFA_BIT_DIV      0
`define CFA_FLAGS_RST    5'h1F
`define CFA_MASK_RST     5'h1F
`define CFA_RSV_RST      3'h0
`define CFA_CTRL_RST     1'h0

`endif

// ===== rtl/cfa_pkg.sv
// types of the converter fault aggregator
// assumes cfa_map.svh supplies the numbers
package cfa_pkg;

   // one bit per fault source, msb first as in the flag register
   typedef struct packed {
      logic lock_loss;
      logic link_down;
      logic realign;
      logic osc_upset;
      logic div_mismatch;
   } cfa_cond_t;

   // apb request as decoded from the bus
   typedef struct packed {
      logic        write;
      logic [11:0] addr;
   } cfa_req_t;

   // slave phase, one-hot
   typedef enum logic [1:0] {
      CFA_IDLE   = 2'b01,
      CFA_ACCESS = 2'b10
   } cfa_phase_t;

endpackage

// ===== rtl/cfa_sync3.sv
// three-stage synchroniser with agreement filter, one per bit
// assumes din changes slowly compared with pclk
`timescale 1ns/100ps
module cfa_sync3
#(
   parameter int W = 1
)
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   genvar g;
   generate
      for (g = 0; g < W; g++)
      begin : g_bit
         logic s1_q, s2_q, s3_q, f_q, f_d;
         // output follows only once stage two and three agree
         always_comb
         begin
            f_d = (s2_q == s3_q) ? s3_q : f_q;
         end
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
               f_q  <= 1'b0;
            end
            else
            begin
               s1_q <= din[g];
               s2_q <= s1_q;
               s3_q <= s2_q;
               f_q  <= f_d;
            end
         end
         assign dout[g] = f_q;
      end
   endgenerate
endmodule

// ===== rtl/cfa_flag_bank.sv
// sticky fault flags, set by hardware, cleared by writing one
// assumes set and clr come from the pclk domain
`timescale 1ns/100ps
`include "cfa_map.svh"
module cfa_flag_bank
(
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic [`CFA_NFLAG-1:0]  set,
   input  wire logic [`CFA_NFLAG-1:0]  clr,
   output logic      [`CFA_NFLAG-1:0]  flags
);
   localparam logic [`CFA_NFLAG-1:0] RST = `CFA_FLAGS_RST;
   genvar g;
   generate
      for (g = 0; g < `CFA_NFLAG; g++)
      begin : g_flag
         logic q, d;
         // set beats clear, so a live fault re-arms at once
         always_comb
         begin
            d = set[g] | (q & ~clr[g]);
         end
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               q <= RST[g]; // all flags up after reset
            else
               q <= d;
         end
         assign flags[g] = q;
      end
   endgenerate
endmodule

// ===== rtl/cfa_fault_aggregator.sv
// converter fault aggregator: apb registers, fault flags, summary,
// interrupt and status pin routing
// assumes fault inputs are asynchronous levels or event toggles and that
// cal_status_in is already on pclk
`timescale 1ns/100ps
`include "cfa_map.svh"
module cfa_fault_aggregator
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        pll_locked,
   input  wire logic        link_enable,
   input  wire logic        data_encoding_state,
   input  wire logic        realign_toggle,
   input  wire logic        resync_toggle,
   input  wire logic        phase_mismatch,
   input  wire logic        divider_mismatch,
   input  wire logic        cal_status_in,
   output logic             status_output_pin,
   output logic             irq
);

   // synchronised inputs
   logic [6:0]              sync_out;
   logic                    locked_s;
   logic                    link_en_s;
   logic                    enc_s;
   logic                    realign_tog_s;
   logic                    resync_tog_s;
   logic                    phase_mis_s;
   logic                    div_mis_s;

   // toggle history for event detection
   logic                    realign_prev_q;
   logic                    realign_prev_d;
   logic                    resync_prev_q;
   logic                    resync_prev_d;
   logic                    realign_evt;
   logic                    resync_evt;

   // fault conditions and flags
   cfa_pkg::cfa_cond_t      cond;
   logic [`CFA_NFLAG-1:0]   cond_vec;
   logic [`CFA_NFLAG-1:0]   flags;
   logic [`CFA_NFLAG-1:0]   clr;
   logic                    summary;
   logic [`CFA_NFLAG-1:0]   unmasked;

   // software registers
   logic [`CFA_NFLAG-1:0]   mask_q;
   logic [`CFA_NFLAG-1:0]   mask_d;
   logic [2:0]              flag_rsv_q;
   logic [2:0]              flag_rsv_d;
   logic [2:0]              mask_rsv_q;
   logic [2:0]              mask_rsv_d;
   logic                    pin_sel_q;
   logic                    pin_sel_d;
   logic                    pin_q;
   logic                    pin_d;

   // apb slave state
   cfa_pkg::cfa_phase_t     phase_q;
   cfa_pkg::cfa_phase_t     phase_d;
   cfa_pkg::cfa_req_t       req;
   logic [31:0]             rdata_q;
   logic [31:0]             rdata_d;
   logic                    err_q;
   logic                    err_d;
   logic                    setup;
   logic                    wr_en;
   logic                    hit;
   logic [31:0]             rd_mux;

   // bring every asynchronous fault input onto pclk
   // a pin may move at any moment; the filter passes only a level that
   // two stages agree on, so a one-cycle glitch never reaches a flag
   cfa_sync3 #(.W(7)) u_sync
   (
      .pclk    (pclk),
      .presetn (presetn),
      .din     ({pll_locked, link_enable, data_encoding_state,
                 realign_toggle, resync_toggle, phase_mismatch,
                 divider_mismatch}),
      .dout    (sync_out)
   );

   // name the synchronised bits
   assign locked_s      = sync_out[6];
   assign link_en_s     = sync_out[5];
   assign enc_s         = sync_out[4];
   assign realign_tog_s = sync_out[3];
   assign resync_tog_s  = sync_out[2];
   assign phase_mis_s   = sync_out[1];
   assign div_mis_s     = sync_out[0];

   // each change of a filtered toggle is one event
   // history resets to the idle level of the filtered pins, so reset
   // itself never looks like an event
   always_comb
   begin
      realign_prev_d = realign_tog_s;
      resync_prev_d  = resync_tog_s;
      realign_evt    = realign_tog_s ^ realign_prev_q;
      resync_evt     = resync_tog_s ^ resync_prev_q;
   end

   // toggle history register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         realign_prev_q <= 1'b0;
         resync_prev_q  <= 1'b0;
      end
      else
      begin
         realign_prev_q <= realign_prev_d;
         resync_prev_q  <= resync_prev_d;
      end
   end

   // fault conditions; levels hold the flag set while they last
   always_comb
   begin
      cond              = '0;
      cond.lock_loss    = ~locked_s;
      cond.link_down    = link_en_s & ~enc_s;
      cond.realign      = realign_evt;
      cond.osc_upset    = ~link_en_s | resync_evt
                          | phase_mis_s;
      cond.div_mismatch = div_mis_s;
   end

   // place each condition at its flag register bit
   always_comb
   begin
      cond_vec                   = '0;
      cond_vec[`CFA_BIT_LOCK]    = cond.lock_loss;
      cond_vec[`CFA_BIT_LINK]    = cond.link_down;
      cond_vec[`CFA_BIT_REALIGN] = cond.realign;
      cond_vec[`CFA_BIT_OSC]     = cond.osc_upset;
      cond_vec[`CFA_BIT_DIV]     = cond.div_mismatch;
   end

   // write-one-to-clear strobes for the flag register
   // a zero in any position leaves that flag alone
   always_comb
   begin
      clr = '0;
      if (wr_en && req.addr == `CFA_ADDR_FLAGS)
         clr = pwdata[`CFA_NFLAG-1:0];
   end

   // sticky flags with set winning over clear
   // a fault that is still present re-arms its flag at the next edge
   cfa_flag_bank u_flags
   (
      .pclk    (pclk),
      .presetn (presetn),
      .set     (cond_vec),
      .clr     (clr),
      .flags   (flags)
   );

   // summary of unmasked flags, also the interrupt line; the mask only
   // gates the summary and never touches the flags themselves
   assign unmasked = flags & ~mask_q;
   assign summary  = |unmasked;
   assign irq      = summary;

   // apb phase tracking; each transfer waits one setup cycle
   // so a stray penable outside a transfer is never answered
   always_comb
   begin
      phase_d = phase_q;
      case (phase_q)
         cfa_pkg::CFA_IDLE:
            if (psel && !penable)
               phase_d = cfa_pkg::CFA_ACCESS;
         cfa_pkg::CFA_ACCESS:
            if (psel && !penable)
               phase_d = cfa_pkg::CFA_ACCESS;
            else if (!psel || penable)
               phase_d = cfa_pkg::CFA_IDLE;
         default:
            phase_d = cfa_pkg::CFA_IDLE;
      endcase
   end

   // phase register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         phase_q <= cfa_pkg::CFA_IDLE;
      else
         phase_q <= phase_d;
   end

   // request decode taken from the bus itself
   always_comb
   begin
      req.write = pwrite;
      req.addr  = paddr;
      setup     = psel & ~penable;
      wr_en     = psel & penable & req.write
                  & (phase_q == cfa_pkg::CFA_ACCESS) & ~err_q;
   end

   // address decode; anything outside the five words is refused
   always_comb
   begin
      case (paddr)
         `CFA_ADDR_SUMMARY,
         `CFA_ADDR_FLAGS,
         `CFA_ADDR_MASK,
         `CFA_ADDR_CTRL,
         `CFA_ADDR_LIVE:
            hit = 1'b1;
         default:
            hit = 1'b0;
      endcase
   end

   // read multiplexer; narrow registers sit in the low byte
   always_comb
   begin
      rd_mux = '0;
      case (paddr)
         `CFA_ADDR_SUMMARY:
            rd_mux[0] = summary;
         `CFA_ADDR_FLAGS:
            rd_mux[7:0] = {flag_rsv_q, flags};
         `CFA_ADDR_MASK:
            rd_mux[7:0] = {mask_rsv_q, mask_q};
         `CFA_ADDR_CTRL:
            rd_mux[0] = pin_sel_q;
         `CFA_ADDR_LIVE:
            rd_mux[`CFA_NFLAG-1:0] = cond_vec;
         default:
            rd_mux = '0;
      endcase
   end

   // read data and error are latched in the setup cycle
   // latching early keeps prdata steady through the whole access phase
   always_comb
   begin
      rdata_d = rdata_q;
      err_d   = err_q;
      if (setup)
      begin
         if (pwrite)
            rdata_d = 32'h00000000;                  // writes read zero
         else
            rdata_d = rd_mux;
         err_d   = ~hit;
      end
   end

   // read data and error register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rdata_q <= 32'h00000000;
         err_q   <= 1'b0;
      end
      else
      begin
         rdata_q <= rdata_d;
         err_q   <= err_d;
      end
   end

   // answer in the first access cycle
   // every transfer completes with no wait state
   assign pready  = psel & penable & (phase_q == cfa_pkg::CFA_ACCESS);
   assign pslverr = pready & err_q;
   assign prdata  = rdata_q;

   // mask, reserved bits and pin select writes
   // reserved bits of flags and mask are plain storage
   always_comb
   begin
      mask_d     = mask_q;
      mask_rsv_d = mask_rsv_q;
      flag_rsv_d = flag_rsv_q;
      pin_sel_d  = pin_sel_q;
      if (wr_en)
      begin
         case (req.addr)
            `CFA_ADDR_FLAGS:
               flag_rsv_d = pwdata[7:5];
            `CFA_ADDR_MASK:
            begin
               mask_d     = pwdata[`CFA_NFLAG-1:0];
               mask_rsv_d = pwdata[7:5];
            end
            `CFA_ADDR_CTRL:
               pin_sel_d  = pwdata[0];
            default:
               pin_sel_d  = pin_sel_q;
         endcase
      end
   end

   // register the software state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mask_q     <= `CFA_MASK_RST;
         mask_rsv_q <= `CFA_RSV_RST;
         flag_rsv_q <= `CFA_RSV_RST;
         pin_sel_q  <= `CFA_CTRL_RST;
      end
      else
      begin
         mask_q     <= mask_d;
         mask_rsv_q <= mask_rsv_d;
         flag_rsv_q <= flag_rsv_d;
         pin_sel_q  <= pin_sel_d;
      end
   end

   // status pin carries either calibration status or the summary
   // registered so the pin never glitches while flags and mask settle
   always_comb
   begin
      pin_d = pin_sel_q ? summary : cal_status_in;
   end

   // status pin register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pin_q <= 1'b0;
      else
         pin_q <= pin_d;
   end

   assign status_output_pin = pin_q;

endmodule

// ===== dv/cfa_fault_src.sv
// fault source model: turns requested conditions into converter pins
// assumes want is driven from the pclk domain by the bench
`timescale 1ns/100ps
module cfa_fault_src
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire cfa_pkg::cfa_cond_t want,
   output logic                    pll_locked,
   output logic                    data_encoding_state,
   output logic                    realign_toggle,
   output logic                    resync_toggle,
   output logic                    divider_mismatch
);
   cfa_pkg::cfa_cond_t want_q;
   logic               rt_q;
   logic               rs_q;

   // events toggle once on each rising request
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         want_q <= '0;
         rt_q   <= 1'b0;
         rs_q   <= 1'b0;
      end
      else
      begin
         want_q <= want;
         rt_q   <= rt_q ^ (want.realign & ~want_q.realign);
         rs_q   <= rs_q ^ (want.osc_upset & ~want_q.osc_upset);
      end
   end

   // level conditions follow the request directly
   assign pll_locked          = ~want.lock_loss;
   assign data_encoding_state = ~want.link_down;
   assign realign_toggle      = rt_q;
   assign resync_toggle       = rs_q;
   assign divider_mismatch    = want.div_mismatch;
endmodule

// ===== dv/cfa_fault_aggregator_asserts.sv
// port checker of the fault aggregator
// assumes one pclk domain and zero wait state apb
`timescale 1ns/100ps
`include "cfa_map.svh"
module cfa_fault_aggregator_asserts
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic        cal_status_in,
   input  wire logic        status_output_pin,
   input  wire logic        irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc;
   logic wr_seen_q;
   logic wr_seen_d;

   // remembers whether the mask was ever written
   assign acc = psel & penable & pready;
   always_comb wr_seen_d = wr_seen_q
      | (acc & pwrite & (paddr == `CFA_ADDR_MASK));
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn) wr_seen_q <= 1'b0;
      else          wr_seen_q <= wr_seen_d;
   end

   a_ready_access: assert property (psel && penable |-> pready)
      else $error("access without ready");
   a_ready_gated: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held two cycles");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_unmapped_err: assert property (psel && penable
      && paddr < `CFA_ADDR_SUMMARY |-> pslverr)
      else $error("unmapped access accepted");
   a_summary_read: assert property (acc && !pwrite
      && paddr == `CFA_ADDR_SUMMARY |-> prdata == {31'h0, $past(irq)})
      else $error("summary read wrong");
   a_irq_fall: assert property ($fell(irq) |->
      $past(psel && penable && pwrite && pready))
      else $error("interrupt dropped without write");
   a_quiet_mask: assert property (!wr_seen_q |-> !irq)
      else $error("interrupt before unmask");
   a_pin_source: assert property (status_output_pin |->
      $past(irq) || $past(cal_status_in))
      else $error("status pin without source");

   c_irq: cover property ($rose(irq));
   c_err: cover property (pslverr);
   c_pin: cover property (status_output_pin && !cal_status_in);
endmodule

bind cfa_fault_aggregator cfa_fault_aggregator_asserts u_chk
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .cal_status_in(cal_status_in),
   .status_output_pin(status_output_pin), .irq(irq)
);

// ===== dv/cfa_fault_aggregator_tb.sv
// self-checking bench of the fault aggregator
// assumes the fault source model and the bound checker
`timescale 1ns/100ps
`include "cfa_map.svh"
module cfa_fault_aggregator_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rv;
   logic pready, pslverr, pll_locked, data_encoding_state, realign_toggle;
   logic resync_toggle, divider_mismatch, status_output_pin, irq, ev;
   logic link_enable = 1, phase_mismatch = 0, cal_status_in = 0;
   cfa_pkg::cfa_cond_t want = '0;
   logic [4:0] r, m;
   int err_total = 0, n_compared = 0, cyc = 0, seed = 61114;

   always #50 pclk = ~pclk;

   cfa_fault_src u_src (.pclk(pclk), .presetn(presetn), .want(want),
      .pll_locked(pll_locked), .data_encoding_state(data_encoding_state),
      .realign_toggle(realign_toggle), .resync_toggle(resync_toggle),
      .divider_mismatch(divider_mismatch));
   cfa_fault_aggregator dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pll_locked(pll_locked), .link_enable(link_enable),
      .data_encoding_state(data_encoding_state),
      .realign_toggle(realign_toggle), .resync_toggle(resync_toggle),
      .phase_mismatch(phase_mismatch), .divider_mismatch(divider_mismatch),
      .cal_status_in(cal_status_in), .status_output_pin(status_output_pin),
      .irq(irq));

   // expected summary from flags and mask
   function automatic logic exp_sum(input logic [4:0] f, input logic [4:0] k);
      return |(f & ~k);
   endfunction

   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e)
      begin
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
         err_total++;
      end
   endtask

   // one apb transfer, held until ready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // request stands until pready is seen high at a rising edge
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rv = prdata;
      ev = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1, a, d);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(0, a, '0);
      chk(rv, e);
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic see_irq(input logic e);
      @(negedge pclk);
      chk({31'h0, irq}, {31'h0, e});
   endtask

   // looks at the status pin mid-cycle, returns on a rising edge
   task automatic see_pin(input logic e);
      @(negedge pclk);
      chk({31'h0, status_output_pin}, {31'h0, e});
      @(posedge pclk);
   endtask

   // cuts a hang short
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         give_verdict();
      end
   end

   initial
   begin
      wt(8);
      presetn <= 1;
      rd(`CFA_ADDR_FLAGS, 32'h1F);
      rd(`CFA_ADDR_MASK, 32'h1F);
      rd(`CFA_ADDR_SUMMARY, 32'h0);
      wt(10);
      wr(`CFA_ADDR_FLAGS, 32'hFF);
      rd(`CFA_ADDR_FLAGS, 32'hE0);
      wr(`CFA_ADDR_FLAGS, 32'h00);
      rd(`CFA_ADDR_FLAGS, 32'h00);
      apb(0, 12'h004, '0);
      chk({31'h0, ev}, 32'h1);
      $display("reset and access test done");
      // one-hot sources first, then random mixes
      for (int k = 0; k < 13; k++)
      begin
         r = (k < 5) ? 5'h01 << k : 5'($random(seed));
         m = (k < 5) ? 5'h00 : 5'($random(seed));
         wr(`CFA_ADDR_MASK, {27'h0, m});
         want <= r;
         wt(8);
         want <= '0;
         wt(8);
         rd(`CFA_ADDR_FLAGS, {27'h0, r});
         see_irq(exp_sum(r, m));
         rd(`CFA_ADDR_SUMMARY, {31'h0, exp_sum(r, m)});
         wr(`CFA_ADDR_FLAGS, 32'h0);
         rd(`CFA_ADDR_FLAGS, {27'h0, r});
         wr(`CFA_ADDR_MASK, 32'h1F);
         see_irq(1'b0);
         rd(`CFA_ADDR_FLAGS, {27'h0, r});
         wr(`CFA_ADDR_FLAGS, 32'h1F);
         rd(`CFA_ADDR_FLAGS, 32'h0);
      end
      $display("source and mask test done");
      want.div_mismatch <= 1;
      wt(8);
      rd(`CFA_ADDR_LIVE, 32'h01);
      wr(`CFA_ADDR_FLAGS, 32'h01);
      rd(`CFA_ADDR_FLAGS, 32'h01);
      want <= '0;
      link_enable <= 0;
      wt(8);
      link_enable <= 1;
      wt(8);
      wr(`CFA_ADDR_FLAGS, 32'h01);
      rd(`CFA_ADDR_FLAGS, 32'h02);
      wr(`CFA_ADDR_FLAGS, 32'h02);
      phase_mismatch <= 1;
      wt(8);
      phase_mismatch <= 0;
      wt(8);
      rd(`CFA_ADDR_FLAGS, 32'h02);
      $display("persist and oscillator test done");
      wr(`CFA_ADDR_CTRL, 32'h0);
      cal_status_in <= 1;
      wt(3);
      see_pin(1'b1);
      cal_status_in <= 0;
      wr(`CFA_ADDR_MASK, 32'h0);
      wt(3);
      see_pin(1'b0);
      wr(`CFA_ADDR_CTRL, 32'h1);
      rd(`CFA_ADDR_CTRL, 32'h1);
      wt(3);
      see_pin(1'b1);
      wr(`CFA_ADDR_SUMMARY, 32'hFF);
      rd(`CFA_ADDR_SUMMARY, 32'h1);
      $display("status pin test done");
      give_verdict();
   end
endmodule
